/* File: verilog/gpio_group_pkg.sv */
/*
  Constants for one GPIO port group: register map, field positions, reset values.
  Assumes a 32-bit APB master and a 50 MHz ref_clk.
*/
// Notes on behaviour
// - with output off and pull on, pull up if direction 1, else down
// - input path and output driver enabled independently; neither and no pull floats
// - non-GPIO pins: GPIO control bits read 0, clearing select returns reset state
// - peripheral-selected pins take direction and data from the peripheral
// - enabled GPIO output drives the output value bit
// - input value read shows the pin sampled one clock before the read; here four clocks before the setup edge, debounce off
// - per-pin debounce enable suppresses pulses shorter than the sampling time
// - sampling time spans two to three filter clock periods
// - sleep with filter clock stopped bypasses debounce
// - reset request when all pins of the selected key set are low
// - key reset follows the filtered levels, immediate when debounce is off
// - key pins remain normal GPIO inputs with working interrupts
// - flag sets on falling edge if edge select is 1, rising if 0
// - writing 1 clears a flag, writing 0 does nothing
// - interrupt request only while a flag and its enable are both set
// - group summary follows enabled flags only
// - interrupts only on interrupt-capable pins in GPIO mode
// - data register: output values in 15..8, read-only inputs in 7..0
// - input value reads 0 while input enable is 0
// - output enable 0 puts the driver in high impedance
package gpio_group_pkg;
  localparam int NPIN = 8;
  // byte addresses of the registers
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_IOEN = 8'h04;
  localparam logic [7:0] ADDR_RCTL = 8'h08;
  localparam logic [7:0] ADDR_INTF = 8'h0c;
  localparam logic [7:0] ADDR_INTCTL = 8'h10;
  localparam logic [7:0] ADDR_CHATEN = 8'h14;
  localparam logic [7:0] ADDR_MODSEL = 8'h18;
  localparam logic [7:0] ADDR_FNCSEL = 8'h1c;
  localparam logic [7:0] ADDR_PCTL = 8'h20;
  localparam logic [7:0] ADDR_GRPF = 8'h24;
  // field positions: high and low byte of the 16-bit registers, key set select and sleep-stop bit
  localparam int HI_LSB = 8;
  localparam int LO_LSB = 0;
  localparam int KEY_LSB = 0;
  localparam int SLPSTOP_BIT = 4;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_FNC = 16'h0000;
  localparam logic [1:0] RST_KEY = 2'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  // filter: new level must be seen at this many consecutive ticks
  localparam int FILT_TICKS = 3;
  typedef enum logic [1:0] {KEY_OFF, KEY_P01, KEY_P012, KEY_P0123} keySet_t;
endpackage

/* File: verilog/gpio_port_group.sv */
/*
  One GPIO port group of eight pins: drive, pulls, peripheral handover,
  debounce, edge interrupts with group summary, key-entry reset, APB registers.
  Assumes pin inputs synchronous to ref_clk in principle, but still resyncs them;
  portFiltClk is a slow clock from the clock generator, sampled as a level.
*/
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module gpio_port_group #(
  parameter logic [7:0] GPIO_CAP = 8'hff,
  parameter logic [7:0] IRQ_CAP = 8'hff,
  parameter logic [7:0] FILT_CAP = 8'hff
) (
  // clock and reset
  input wire logic refClk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic [7:0] pullUpEn,
  output logic [7:0] pullDownEn,
  // peripheral side
  input wire logic [7:0] periphOut,
  input wire logic [7:0] periphOe,
  output logic [7:0] periphIn,
  output logic [15:0] periphFunc,
  // system
  input wire logic portFiltClk,
  input wire logic sleepMode,
  output logic irqReq,
  output logic keyResetReq
);

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] outQ, ienQ, oeQ, pdpuQ, renQ, flagQ, edgeQ, ieQ, chatQ, selQ;
  logic [15:0] fncQ;
  logic [1:0] keyQ;
  logic slpStopQ;
  logic prdyQ, errQ, irqQ, keyReqQ;
  logic [31:0] rdQ;
  logic [7:0] inValQ;
  logic [7:0] pinOutQ, pinOeQ, puQ, pdQ, perInQ;

  logic setupPh, wrEn, mapped;
  logic [7:0] wHi, wLo, flagSet, fltQ, fltPrevQ;

  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && prdyQ && pwrite;
  assign wHi = pwdata[gpio_group_pkg::HI_LSB +: 8];
  assign wLo = pwdata[gpio_group_pkg::LO_LSB +: 8];

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] r);
    return wrEn && a == r;
  endfunction

  // GPIO-only bits are forced to zero on pins without GPIO
  function automatic logic [7:0] gpioBits(input logic [7:0] v);
    return v & GPIO_CAP;
  endfunction

  always_comb begin
    case (paddr)
      gpio_group_pkg::ADDR_DATA, gpio_group_pkg::ADDR_IOEN,
      gpio_group_pkg::ADDR_RCTL, gpio_group_pkg::ADDR_INTF,
      gpio_group_pkg::ADDR_INTCTL, gpio_group_pkg::ADDR_CHATEN,
      gpio_group_pkg::ADDR_MODSEL, gpio_group_pkg::ADDR_FNCSEL,
      gpio_group_pkg::ADDR_PCTL, gpio_group_pkg::ADDR_GRPF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      outQ <= gpio_group_pkg::RST_BYTE;
      ienQ <= gpio_group_pkg::RST_BYTE;
      oeQ <= gpio_group_pkg::RST_BYTE;
      pdpuQ <= gpio_group_pkg::RST_BYTE;
      renQ <= gpio_group_pkg::RST_BYTE;
      edgeQ <= gpio_group_pkg::RST_BYTE;
      ieQ <= gpio_group_pkg::RST_BYTE;
      chatQ <= gpio_group_pkg::RST_BYTE;
      selQ <= gpio_group_pkg::RST_BYTE;
      fncQ <= gpio_group_pkg::RST_FNC;
      keyQ <= gpio_group_pkg::RST_KEY;
      slpStopQ <= 1'b0;
    end else begin
      if (isAddr(paddr, gpio_group_pkg::ADDR_DATA)) begin
        outQ <= gpioBits(wHi);
      end
      if (isAddr(paddr, gpio_group_pkg::ADDR_IOEN)) begin
        ienQ <= gpioBits(wHi);
        oeQ <= gpioBits(wLo);
      end
      if (isAddr(paddr, gpio_group_pkg::ADDR_RCTL)) begin
        pdpuQ <= gpioBits(wHi);
        renQ <= gpioBits(wLo);
      end
      if (isAddr(paddr, gpio_group_pkg::ADDR_INTCTL)) begin
        edgeQ <= wHi & IRQ_CAP & GPIO_CAP;
        ieQ <= wLo & IRQ_CAP & GPIO_CAP;
      end
      if (isAddr(paddr, gpio_group_pkg::ADDR_CHATEN)) begin
        chatQ <= wLo & FILT_CAP;
      end
      if (isAddr(paddr, gpio_group_pkg::ADDR_MODSEL)) begin
        selQ <= wLo;
      end
      if (isAddr(paddr, gpio_group_pkg::ADDR_FNCSEL)) begin
        fncQ <= pwdata[15:0];
      end
      if (isAddr(paddr, gpio_group_pkg::ADDR_PCTL)) begin
        keyQ <= pwdata[gpio_group_pkg::KEY_LSB +: 2];
        slpStopQ <= pwdata[gpio_group_pkg::SLPSTOP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser and filter clock tick
  logic [7:0] syncAQ, syncBQ;
  logic fcAQ, fcBQ, fcCQ, tick;

  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      syncAQ <= gpio_group_pkg::RST_BYTE;
      syncBQ <= gpio_group_pkg::RST_BYTE;
      fcAQ <= 1'b0;
      fcBQ <= 1'b0;
      fcCQ <= 1'b0;
    end else begin
      syncAQ <= pinIn;
      syncBQ <= syncAQ;
      fcAQ <= portFiltClk;
      fcBQ <= fcAQ;
      fcCQ <= fcBQ;
    end
  end

  assign tick = fcBQ && !fcCQ;

  ////////////////////////////////////////////////////////////////////////////
  // debounce: a level passes once seen at three consecutive filter ticks,
  // i.e. held across two to three filter periods
  logic [7:0] smp1Q, smp2Q, bypass;
  logic slpStopped;

  // a stopped filter clock in sleep would freeze the pins, so bypass
  assign slpStopped = sleepMode && slpStopQ;
  assign bypass = ~chatQ | {8{slpStopped}};

  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      smp1Q <= gpio_group_pkg::RST_BYTE;
      smp2Q <= gpio_group_pkg::RST_BYTE;
      fltQ <= gpio_group_pkg::RST_BYTE;
    end else begin
      if (tick) begin
        smp1Q <= syncBQ;
        smp2Q <= smp1Q;
      end
      for (int i = 0; i < 8; i++) begin
        if (bypass[i]) begin
          fltQ[i] <= syncBQ[i];
        end else if (tick && syncBQ[i] == smp1Q[i] && smp1Q[i] == smp2Q[i]) begin
          fltQ[i] <= smp2Q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input value, edge flags, summary
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      inValQ <= gpio_group_pkg::RST_BYTE;
      fltPrevQ <= gpio_group_pkg::RST_BYTE;
    end else begin
      inValQ <= fltQ & ienQ & ~selQ & GPIO_CAP;
      fltPrevQ <= fltQ;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      flagSet[i] = (edgeQ[i] ? (fltPrevQ[i] && !fltQ[i])
                             : (!fltPrevQ[i] && fltQ[i]));
    end
    flagSet = flagSet & IRQ_CAP & GPIO_CAP & ~selQ;
  end

  // a new edge in the clearing cycle keeps the flag
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      flagQ <= gpio_group_pkg::RST_BYTE;
    end else if (isAddr(paddr, gpio_group_pkg::ADDR_INTF)) begin
      flagQ <= (flagQ & ~wLo) | flagSet;
    end else begin
      flagQ <= flagQ | flagSet;
    end
  end

  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      irqQ <= 1'b0;
    end else begin
      irqQ <= |(flagQ & ieQ);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key-entry reset on the filtered levels of pins 0..3
  logic keyHit;

  always_comb begin
    case (gpio_group_pkg::keySet_t'(keyQ))
      gpio_group_pkg::KEY_OFF: keyHit = 1'b0;
      gpio_group_pkg::KEY_P01: keyHit = ~|fltQ[1:0];
      gpio_group_pkg::KEY_P012: keyHit = ~|fltQ[2:0];
      gpio_group_pkg::KEY_P0123: keyHit = ~|fltQ[3:0];
      default: keyHit = 1'b0;
    endcase
  end

  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      keyReqQ <= 1'b0;
    end else begin
      keyReqQ <= keyHit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad and peripheral outputs
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      pinOutQ <= gpio_group_pkg::RST_BYTE;
      pinOeQ <= gpio_group_pkg::RST_BYTE;
      puQ <= gpio_group_pkg::RST_BYTE;
      pdQ <= gpio_group_pkg::RST_BYTE;
      perInQ <= gpio_group_pkg::RST_BYTE;
    end else begin
      pinOutQ <= (selQ & periphOut) | (~selQ & outQ);
      pinOeQ <= (selQ & periphOe) | (~selQ & oeQ);
      puQ <= ~selQ & ~oeQ & renQ & pdpuQ;
      pdQ <= ~selQ & ~oeQ & renQ & ~pdpuQ;
      perInQ <= selQ & syncBQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: read data is captured at the setup edge, write data at the end of the first access cycle, pready in that cycle
  logic [31:0] rdD;

  always_comb begin
    rdD = gpio_group_pkg::RST_RDATA;
    case (paddr)
      gpio_group_pkg::ADDR_DATA: rdD[15:0] = {outQ, inValQ};
      gpio_group_pkg::ADDR_IOEN: rdD[15:0] = {ienQ, oeQ};
      gpio_group_pkg::ADDR_RCTL: rdD[15:0] = {pdpuQ, renQ};
      gpio_group_pkg::ADDR_INTF: rdD[7:0] = flagQ;
      gpio_group_pkg::ADDR_INTCTL: rdD[15:0] = {edgeQ, ieQ};
      gpio_group_pkg::ADDR_CHATEN: rdD[7:0] = chatQ;
      gpio_group_pkg::ADDR_MODSEL: rdD[7:0] = selQ;
      gpio_group_pkg::ADDR_FNCSEL: rdD[15:0] = fncQ;
      gpio_group_pkg::ADDR_PCTL: rdD[4:0] = {slpStopQ, 2'b00, keyQ};
      gpio_group_pkg::ADDR_GRPF: rdD[0] = irqQ;
      default: rdD = gpio_group_pkg::RST_RDATA;
    endcase
  end

  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      prdyQ <= 1'b0;
      errQ <= 1'b0;
      rdQ <= gpio_group_pkg::RST_RDATA;
    end else begin
      prdyQ <= setupPh;
      errQ <= setupPh && !mapped;
      if (setupPh && !pwrite) begin
        rdQ <= rdD;
      end
    end
  end

  assign prdata = rdQ;
  assign pready = prdyQ;
  assign pslverr = errQ;
  assign pinOut = pinOutQ;
  assign pinOe = pinOeQ;
  assign pullUpEn = puQ;
  assign pullDownEn = pdQ;
  assign periphIn = perInQ;
  assign periphFunc = fncQ;
  assign irqReq = irqQ;
  assign keyResetReq = keyReqQ;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge refClk); endclocking
  default disable iff (!arst_n);

  no_pull_drive_a: assert property (
    pinOe[0] && !$past(selQ[0]) |-> !pullUpEn[0] && !pullDownEn[0])
    else $error("pull applied while driving");

  pull_dir_a: assert property (
    !selQ[0] && !oeQ[0] && renQ[0] |=> pullUpEn[0] == $past(pdpuQ[0]))
    else $error("pull direction wrong");

  out_value_a: assert property (
    !selQ[0] && oeQ[0] |=> pinOe[0] && pinOut[0] == $past(outQ[0]))
    else $error("gpio output not driven");

  periph_hand_a: assert property (
    selQ[2] |=> pinOe[2] == $past(periphOe[2]) && pinOut[2] == $past(periphOut[2]))
    else $error("peripheral not in control");

  in_zero_a: assert property (
    !ienQ[0] |=> !inValQ[0])
    else $error("input value not zero");

  flag_rise_a: assert property (
    !selQ[0] && !edgeQ[0] && !fltPrevQ[0] && fltQ[0] |=> flagQ[0])
    else $error("rising edge flag missed");

  flag_clear_a: assert property (
    isAddr(paddr, gpio_group_pkg::ADDR_INTF) && pwdata[0] && !flagSet[0] |=> !flagQ[0])
    else $error("flag not cleared");

  irq_gate_a: assert property (
    irqReq |-> |($past(flagQ) & $past(ieQ)))
    else $error("irq without enabled flag");

  key_req_a: assert property (
    keyHit ##1 keyHit |-> keyResetReq)
    else $error("key reset not raised");

  filt_hold_a: assert property (
    chatQ[0] && !slpStopped && !tick |=> $stable(fltQ[0]))
    else $error("filter moved off tick");

  apb_ready_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb ready timing");

  flag_fall_a: assert property (
    !selQ[1] && edgeQ[1] && fltPrevQ[1] && !fltQ[1] |=> flagQ[1])
    else $error("falling edge flag missed");

  sel_no_flag_a: assert property (
    selQ[2] && !flagQ[2] |=> !flagQ[2])
    else $error("flag set on peripheral pin");

  in_value_a: assert property (
    ienQ[0] && !selQ[0] |=> inValQ[0] == $past(fltQ[0]))
    else $error("input value not sampled");

  summary_off_a: assert property (
    !(|(flagQ & ieQ)) |=> !irqReq)
    else $error("summary set without enabled flag");

  bypass_pass_a: assert property (
    sleepMode && slpStopQ |=> fltQ == $past(syncBQ))
    else $error("filter not bypassed in sleep");

  gpio_cap_a: assert property (
    !GPIO_CAP[7] |-> !ienQ[7] && !oeQ[7] && !renQ[7] && !outQ[7])
    else $error("control bit set on non-gpio pin");

endmodule

/* File: tb/pin_model.sv */
/*
  Pad and board model for the eight pins of one port group.
  Assumes the bench drives extEn/extVal in place of outside circuits.
*/
`timescale 1ns/1ns
module pin_model (
  // clock
  input wire logic refClk,
  // design side
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullUpEn,
  input wire logic [7:0] pullDownEn,
  // outside drivers
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  // resolved level
  output logic [7:0] pinLvl
);
  logic [7:0] floatQ = 8'h00;
  // a floating pin must never look settled, so it toggles every cycle
  always_ff @(posedge refClk) begin
    floatQ <= ~floatQ;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) begin
        pinLvl[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinLvl[i] = extVal[i];
      end else if (pullUpEn[i]) begin
        pinLvl[i] = 1'b1;
      end else if (pullDownEn[i]) begin
        pinLvl[i] = 1'b0;
      end else begin
        pinLvl[i] = floatQ[i];
      end
    end
  end
endmodule

/* File: tb/gpio_port_group_with_debounce_tb_top.sv */
/*
  Self-checking bench for one GPIO port group, driven over APB.
  Assumes pin 7 lacks GPIO capability and a 200 ns filter clock.
*/
`timescale 1ns/1ns
module gpio_port_group_with_debounce_tb_top;
  logic refClk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleepMode = 1'b0, portFiltClk = 1'b0, er;
  logic [7:0] paddr = 8'h00, periphOut = 8'h00, periphOe = 8'h00;
  logic [7:0] extEn = 8'h00, extVal = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic pready, pslverr, irqReq, keyResetReq;
  logic [7:0] pinIn, pinOut, pinOe, pullUpEn, pullDownEn, periphIn;
  logic [15:0] periphFunc;
  int nErrors = 0, checks = 0, cycles = 0;

  always #10 refClk = ~refClk;
  always #100 portFiltClk = ~portFiltClk;

  gpio_port_group #(.GPIO_CAP(8'h7f)) uut (.refClk(refClk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .periphOut(periphOut),
    .periphOe(periphOe), .periphIn(periphIn), .periphFunc(periphFunc),
    .portFiltClk(portFiltClk), .sleepMode(sleepMode), .irqReq(irqReq),
    .keyResetReq(keyResetReq));
  pin_model pins (.refClk(refClk), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .extEn(extEn), .extVal(extVal), .pinLvl(pinIn));

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("errors %0d checks %0d", nErrors, checks);
    if (nErrors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // entered right after an edge; one idle cycle at the end avoids double assignment
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge refClk);
    penable <= 1'b1;
    do begin
      @(posedge refClk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge refClk);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge refClk);
  endtask
  task automatic pls(input int n);
    extVal <= 8'h05;
    cyc(n);
    extVal <= 8'h04;
    cyc(60);
  endtask

  always @(posedge refClk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    arst_n <= 1'b1;
    @(posedge refClk);
    chk("pinOe", pinOe, 32'h0000_0000);
    rc("data", gpio_group_pkg::ADDR_DATA, 32'h0000_0000);
    w(gpio_group_pkg::ADDR_IOEN, 32'h0000_ffff);
    w(gpio_group_pkg::ADDR_DATA, 32'h0000_a5ff);
    rc("ioen", gpio_group_pkg::ADDR_IOEN, 32'h0000_7f7f);
    chk("pinOut", pinOut, 32'h0000_0025);
    chk("pinOe", pinOe, 32'h0000_007f);
    // pin change needs sync, filter and input flops before it reads back
    cyc(4);
    rc("data", gpio_group_pkg::ADDR_DATA, 32'h0000_2525);
    w(gpio_group_pkg::ADDR_IOEN, 32'h0000_007f);
    cyc(5);
    rc("data", gpio_group_pkg::ADDR_DATA, 32'h0000_2500);
    w(gpio_group_pkg::ADDR_IOEN, 32'h0000_0000);
    w(gpio_group_pkg::ADDR_RCTL, 32'h0000_f0ff);
    cyc(1);
    chk("pullUp", pullUpEn, 32'h0000_0070);
    chk("pullDown", pullDownEn, 32'h0000_000f);
    chk("pinOe", pinOe, 32'h0000_0000);
    w(gpio_group_pkg::ADDR_IOEN, 32'h0000_007f);
    cyc(1);
    chk("pulls", pullUpEn | pullDownEn, 32'h0000_0000);
    rc("unmapped", 8'h30, 32'h0000_0000);
    chk("pslverr", er, 32'h0000_0001);
    // inputs and interrupts: pin0 rising, pin1 falling with its enable off
    extEn <= 8'hff;
    extVal <= 8'h02;
    w(gpio_group_pkg::ADDR_RCTL, 32'h0000_00ff);
    w(gpio_group_pkg::ADDR_IOEN, 32'h0000_ff00);
    cyc(8);
    w(gpio_group_pkg::ADDR_INTF, 32'h0000_00ff);
    w(gpio_group_pkg::ADDR_INTCTL, 32'h0000_0201);
    extVal <= 8'h03;
    cyc(8);
    chk("irqReq", irqReq, 32'h0000_0001);
    rc("group", gpio_group_pkg::ADDR_GRPF, 32'h0000_0001);
    w(gpio_group_pkg::ADDR_INTF, 32'h0000_0000);
    rc("flags", gpio_group_pkg::ADDR_INTF, 32'h0000_0001);
    w(gpio_group_pkg::ADDR_INTF, 32'h0000_0001);
    rc("flags", gpio_group_pkg::ADDR_INTF, 32'h0000_0000);
    chk("irqReq", irqReq, 32'h0000_0000);
    extVal <= 8'h01;
    cyc(8);
    rc("flags", gpio_group_pkg::ADDR_INTF, 32'h0000_0002);
    chk("irqReq", irqReq, 32'h0000_0000);
    rc("group", gpio_group_pkg::ADDR_GRPF, 32'h0000_0000);
    // key reset on pins 0-1, set up as inputs beforehand
    w(gpio_group_pkg::ADDR_PCTL, 32'h0000_0001);
    cyc(4);
    chk("keyReset", keyResetReq, 32'h0000_0000);
    extVal <= 8'h04;
    cyc(8);
    chk("keyReset", keyResetReq, 32'h0000_0001);
    rc("data", gpio_group_pkg::ADDR_DATA, 32'h0000_2504);
    w(gpio_group_pkg::ADDR_PCTL, 32'h0000_0000);
    w(gpio_group_pkg::ADDR_INTF, 32'h0000_00ff);
    // peripheral takes pin2; its edges must not reach the flags
    w(gpio_group_pkg::ADDR_FNCSEL, 32'h0000_0030);
    chk("periphFunc", periphFunc, 32'h0000_0030);
    periphOe <= 8'h04;
    periphOut <= 8'h04;
    w(gpio_group_pkg::ADDR_MODSEL, 32'h0000_0004);
    extEn <= 8'hfb;
    w(gpio_group_pkg::ADDR_INTCTL, 32'h0000_0004);
    periphOut <= 8'h00;
    cyc(8);
    chk("pinOe", pinOe, 32'h0000_0004);
    chk("periphIn", periphIn[2], 32'h0000_0000);
    periphOut <= 8'h04;
    cyc(8);
    chk("pinOut", pinOut[2], 32'h0000_0001);
    rc("flags", gpio_group_pkg::ADDR_INTF, 32'h0000_0000);
    chk("irqReq", irqReq, 32'h0000_0000);
    // debounce on pin0
    w(gpio_group_pkg::ADDR_INTCTL, 32'h0000_0000);
    w(gpio_group_pkg::ADDR_CHATEN, 32'h0000_0001);
    cyc(50);
    w(gpio_group_pkg::ADDR_INTF, 32'h0000_00ff);
    w(gpio_group_pkg::ADDR_INTCTL, 32'h0000_0001);
    pls(4);
    rc("flags", gpio_group_pkg::ADDR_INTF, 32'h0000_0000);
    pls(36);
    rc("flags", gpio_group_pkg::ADDR_INTF, 32'h0000_0001);
    w(gpio_group_pkg::ADDR_INTCTL, 32'h0000_0000);
    w(gpio_group_pkg::ADDR_PCTL, 32'h0000_0010);
    sleepMode <= 1'b1;
    cyc(8);
    w(gpio_group_pkg::ADDR_INTF, 32'h0000_00ff);
    pls(4);
    rc("flags", gpio_group_pkg::ADDR_INTF, 32'h0000_0001);
    conclude();
  end
endmodule
